//--- design/sirq_top.sv
// serialized interrupt slave: serirq sequencer, clkrun request, local irqs
// assumes lpc pins arrive asynchronously and the datapath runs on clk_in

module sirq_top
  import sirq_pkg::*;
(
  // system
  input wire logic clk_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // lpc pins
  input wire logic lclk_in,
  input wire logic lreset_n_in,
  input wire logic lpcpd_n_in,
  input wire logic serirq_in,
  output logic serirq_out,
  output logic serirq_oe_out,
  input wire logic clkrun_in,
  output logic clkrun_out,
  output logic clkrun_oe_out,
  // datapath events
  input wire logic [2:0] output_data_reg_read_in,
  input wire logic [2:0] input_data_reg_full_in,
  input wire logic twoway_reg_last_full_in,
  input wire logic [4:0] hs_evt_in,
  input wire logic [11:0] blk_evt_in,
  input wire logic cycle_abort_evt_in,
  // local irqs
  output logic rx_done_irq_ch1_out,
  output logic rx_done_irq_ch2_out,
  output logic rx_done_irq_ch3_out,
  output logic error_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and lpc reset decode

  logic [4:0] pin_s;
  logic lclk_s;
  logic lreset_n_s;
  logic lpcpd_n_s;
  logic serirq_s;
  logic clkrun_s;
  logic lclk_prev_q;
  logic lclk_rise;
  logic lclk_fall;
  logic lpc_rst;
  logic shutdown;
  logic seq_rst;
  logic [CTRL_W-1:0] ctrl_q;

  sirq_sync #(
    .WIDTH(5),
    .RST_VAL(5'h1f)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in({clkrun_in, serirq_in, lpcpd_n_in, lreset_n_in, lclk_in}),
    .q_out(pin_s)
  );

  assign lclk_s = pin_s[0];
  assign lreset_n_s = pin_s[1];
  assign lpcpd_n_s = pin_s[2];
  assign serirq_s = pin_s[3];
  assign clkrun_s = pin_s[4];
  assign lclk_rise = lclk_s & ~lclk_prev_q;
  assign lclk_fall = ~lclk_s & lclk_prev_q;
  assign lpc_rst = ~lreset_n_s;
  assign shutdown = ~lpcpd_n_s | ctrl_q[CTRL_SWSHUT];
  // every reset source clears the sequencer
  assign seq_rst = rst_in | lpc_rst | shutdown;

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic ack_d;
  logic ack_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic wr_ok;
  logic [CTRL_W-1:0] ctrl_d;
  logic [HIRQ_W-1:0] hirq_d;
  logic [HIRQ_W-1:0] hirq_q;
  logic [HIRQ_W-1:0] hw_clr;
  logic [2:0] flag_d;
  logic [2:0] flag_q;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic lpc_rst_prev_q;
  logic shutdown_prev_q;
  logic [3:0] local_irq;
  logic [31:0] stat_img;
  logic quiet_q;
  logic ckrq_q;
  sirq_seq_t seq_q;

  // one wait cycle per access gives time to register the read data
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
  assign avs_readdata_out = rdata_q;
  assign wr_ok = avs_write_in & ack_q;

  always_comb
  begin
    stat_img = 32'h0;
    stat_img[STAT_QUIET] = quiet_q;
    stat_img[STAT_CKRQ] = ckrq_q;
    stat_img[STAT_BUSY] = (seq_q != SQ_IDLE);
    stat_img[STAT_ABORT:STAT_HRST] = flag_q;
    stat_img[STAT_IRQ_LO +: 4] = local_irq;
    ack_d = (avs_read_in | avs_write_in) & ~ack_q;
    case (avs_address_in)
      OFS_CTRL: rdata_d = {25'h0, ctrl_q};
      OFS_HIRQ: rdata_d = {20'h0, hirq_q};
      OFS_STAT: rdata_d = stat_img;
      default: rdata_d = 32'h0;
    endcase
    ctrl_d = ctrl_q;
    if (wr_ok && avs_address_in == OFS_CTRL)
    begin
      ctrl_d = CTRL_W'(sirq_merge({25'h0, ctrl_q}, avs_writedata_in, avs_byteenable_in));
    end
    // host read of an output register withdraws that channel's requests, for channels two and three only when CTRL_DIRECT is clear
    hw_clr = 12'h000;
    hw_clr[HIRQ_IRQ12_C1:HIRQ_IRQ1_C1] = {2{output_data_reg_read_in[0]}};
    hw_clr[HIRQ_C2_LO +: 5] = {5{output_data_reg_read_in[1] & ~ctrl_q[CTRL_DIRECT]}};
    hw_clr[HIRQ_C3_LO +: 5] = {5{output_data_reg_read_in[2] & ~ctrl_q[CTRL_DIRECT]}};
    hirq_d = hirq_q & ~hw_clr;
    // software write lands after the hardware clear, so its set wins
    if (wr_ok && avs_address_in == OFS_HIRQ)
    begin
      hirq_d = HIRQ_W'(sirq_merge({20'h0, hirq_d}, avs_writedata_in, avs_byteenable_in));
    end
    flag_set = {cycle_abort_evt_in, shutdown & ~shutdown_prev_q, lpc_rst & ~lpc_rst_prev_q};
    flag_clr = 3'h0;
    if (wr_ok && avs_address_in == OFS_STAT && avs_byteenable_in[0])
    begin
      flag_clr = avs_writedata_in[STAT_ABORT:STAT_HRST];
    end
    flag_d = (flag_q & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
      ctrl_q <= CTRL_RST;
      flag_q <= 3'h0;
      lpc_rst_prev_q <= 1'b0;
      shutdown_prev_q <= 1'b0;
      lclk_prev_q <= 1'b1;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      // lpc reset clears the shutdown flag unless shutdown rises in the same cycle
      flag_q <= {flag_d[2], flag_d[1] & ~(lpc_rst & ~flag_set[1]), flag_d[0]};
      lpc_rst_prev_q <= lpc_rst;
      shutdown_prev_q <= shutdown;
      lclk_prev_q <= lclk_s;
    end
  end

  // host enables survive shutdown but not an lpc reset
  always_ff @(posedge clk_in)
  begin
    if (rst_in || lpc_rst)
    begin
      hirq_q <= HIRQ_RST;
    end
    else
    begin
      hirq_q <= hirq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame request map

  logic [17:0] req_vec;
  logic pending;

  always_comb
  begin
    req_vec = 18'h0;
    req_vec[FRAME_IRQ1] = hirq_q[HIRQ_IRQ1_C1];
    req_vec[FRAME_IRQ12] = hirq_q[HIRQ_IRQ12_C1];
    req_vec[FRAME_SMI] = hirq_q[HIRQ_C2_LO] | hirq_q[HIRQ_C3_LO];
    req_vec[FRAME_IRQ6] = hirq_q[HIRQ_C2_LO + 1] | hirq_q[HIRQ_C3_LO + 1];
    for (int i = 0; i < 3; i++)
    begin
      req_vec[FRAME_IRQ9 + 5'(i)] = hirq_q[HIRQ_C2_LO + 2 + i] | hirq_q[HIRQ_C3_LO + 2 + i];
    end
    pending = |req_vec;
  end

  ////////////////////////////////////////////////////////////////////////////
  // serirq sequencer: sample at lclk fall, drive at lclk rise

  sirq_seq_t seq_d;
  logic [4:0] frame_d;
  logic [4:0] frame_q;
  logic [1:0] phase_d;
  logic [1:0] phase_q;
  logic [2:0] low_d;
  logic [2:0] low_q;
  logic drove_d;
  logic drove_q;
  logic samp_d;
  logic samp_q;
  logic oe_d;
  logic oe_q;
  logic lvl_d;
  logic lvl_q;
  logic quiet_d;

  always_comb
  begin
    seq_d = seq_q;
    frame_d = frame_q;
    phase_d = phase_q;
    low_d = low_q;
    drove_d = drove_q;
    oe_d = oe_q;
    lvl_d = lvl_q;
    quiet_d = quiet_q;
    // mid-state sampling keeps clear of the edge where the line changes
    samp_d = lclk_fall ? serirq_s : samp_q;
    if (lclk_rise)
    begin
      case (seq_q)
        SQ_IDLE:
        begin
          // a low line opens the start frame
          if (!samp_q)
          begin
            seq_d = SQ_START;
          end
          // self start only in quiet mode, one low state
          else if (quiet_q && pending)
          begin
            seq_d = SQ_START;
            oe_d = 1'b1;
            lvl_d = 1'b0;
          end
        end
        SQ_START:
        begin
          // host drives the rest of the start frame
          oe_d = 1'b0;
          if (samp_q)
          begin
            seq_d = SQ_FRAME;
            frame_d = 5'h00;
            phase_d = PH_TURN;
          end
        end
        SQ_FRAME:
        begin
          case (phase_q)
            PH_TURN:
            begin
              if (frame_q == FRAME_LAST)
              begin
                seq_d = SQ_STOP;
                low_d = 3'h0;
              end
              else
              begin
                frame_d = 5'(frame_q + 5'h01);
                phase_d = PH_SAMPLE;
                // low in the first state of an active frame
                drove_d = req_vec[5'(frame_q + 5'h01)];
                oe_d = req_vec[5'(frame_q + 5'h01)];
                lvl_d = 1'b0;
              end
            end
            PH_SAMPLE:
            begin
              // recover driven high by the state's driver
              phase_d = PH_RECOVER;
              oe_d = drove_q;
              lvl_d = 1'b1;
            end
            default:
            begin
              phase_d = PH_TURN;
              oe_d = 1'b0;
            end
          endcase
        end
        default:
        begin
          // low length of the stop pulse picks the next mode
          if (!samp_q)
          begin
            low_d = (low_q == 3'h7) ? low_q : 3'(low_q + 3'h1);
          end
          else if (low_q != 3'h0)
          begin
            quiet_d = (low_q == STOP_QUIET_LOW);
            seq_d = SQ_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    // sequencer cleared and pin released in every reset
    if (seq_rst)
    begin
      seq_q <= SQ_IDLE;
      frame_q <= 5'h00;
      phase_q <= PH_TURN;
      low_q <= 3'h0;
      drove_q <= 1'b0;
      samp_q <= 1'b1;
      oe_q <= 1'b0;
      lvl_q <= 1'b1;
    end
    else
    begin
      seq_q <= seq_d;
      frame_q <= frame_d;
      phase_q <= phase_d;
      low_q <= low_d;
      drove_q <= drove_d;
      samp_q <= samp_d;
      oe_q <= oe_d;
      lvl_q <= lvl_d;
    end
  end

  // mode flag survives shutdown, continuous after reset
  always_ff @(posedge clk_in)
  begin
    if (rst_in || lpc_rst)
    begin
      quiet_q <= 1'b0;
    end
    else
    begin
      quiet_q <= quiet_d;
    end
  end

  assign serirq_oe_out = oe_q;
  assign serirq_out = lvl_q;

  ////////////////////////////////////////////////////////////////////////////
  // clock restart request on clkrun

  logic ckrq_d;
  logic [7:0] hold_d;
  logic [7:0] hold_q;
  logic crun_oe_d;
  logic crun_oe_q;

  always_comb
  begin
    ckrq_d = ckrq_q;
    hold_d = (hold_q != 8'h00) ? 8'(hold_q - 8'h01) : hold_q;
    // request a restart only in quiet mode while idle
    if (!quiet_q || !pending || seq_q != SQ_IDLE)
    begin
      ckrq_d = 1'b0;
    end
    else if (!ckrq_q && clkrun_s)
    begin
      ckrq_d = 1'b1;
      hold_d = 8'(CLKRUN_HOLD_CYC);
    end
    crun_oe_d = (hold_d != 8'h00);
  end

  always_ff @(posedge clk_in)
  begin
    if (seq_rst)
    begin
      ckrq_q <= 1'b0;
      hold_q <= 8'h00;
      crun_oe_q <= 1'b0;
    end
    else
    begin
      ckrq_q <= ckrq_d;
      hold_q <= hold_d;
      crun_oe_q <= crun_oe_d;
    end
  end

  // open drain: only ever pulls low
  assign clkrun_oe_out = crun_oe_q;
  assign clkrun_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // local slave interrupts

  sirq_local_irq u_local_irq (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .rx_en_in(ctrl_q[CTRL_EN3:CTRL_EN1]),
    .error_irq_en_in(ctrl_q[CTRL_ERREN]),
    .twoway_reg_enable_in(ctrl_q[CTRL_TWOWAY]),
    .rxreg_full_in(input_data_reg_full_in),
    .twoway_last_full_in(twoway_reg_last_full_in),
    .hs_evt_in(hs_evt_in),
    .blk_evt_in(blk_evt_in),
    .err_flags_in(flag_q),
    .irq_out(local_irq)
  );

  assign rx_done_irq_ch1_out = local_irq[0];
  assign rx_done_irq_ch2_out = local_irq[1];
  assign rx_done_irq_ch3_out = local_irq[2];
  assign error_irq_out = local_irq[3];

endmodule // sirq_top

//--- design/sirq_pkg.sv
// constants, types and helpers for the serialized interrupt slave
// assumes a 100 MHz system clock and an lpc datapath on the same clock
//
// Functional notes
// - count lclk states from the start frame; drive requests only in their frame
// - each frame ends with recover driven high, then an undriven turnaround
// - start frame is six states; slave may drive only its first, quiet mode
// - frames 1 to 17, three states each, irq0 through iochck, slave drives
// - irq1 and irq12 frames are driven only by channel one requests
// - smi, irq6, irq9, irq10, irq11 frames come from channel two or three
// - measure stop frame low length; two means quiet next, three continuous
// - continuous mode: host starts cycles, device never starts one
// - quiet mode: device may start a cycle when a request is pending
// - quiet mode host may stop lclk; device first asks for a restart
// - quiet mode pending request drives clkrun low to restart lclk
// - no clock restart request for data transfers or in continuous mode
// - local irq one and two: enable set and input register one/two full
// - local irq three: register three full, or two-way last register written
// - local irq three also raised by any handshake mode event
// - local irq three also raised by any block transfer mode event
// - error irq: enable set and host reset, shutdown or abort flag set
// - system reset, lpc reset and shutdown all reset the sequencer; lpc reset and shutdown set their flags
// - in reset and shutdown the serirq and clkrun pins are not driven
// - linked clearing: host output register read clears the host irq enables; channel two and three reads clear nothing while CTRL_DIRECT is set

package sirq_pkg;

  localparam int CLK_MHZ = 100;
  // clkrun low pulse, long enough for a host to notice with lclk stopped
  localparam int CLKRUN_HOLD_NS = 250;
  localparam int CLKRUN_HOLD_CYC = (CLKRUN_HOLD_NS * CLK_MHZ + 999) / 1000;

  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_HIRQ = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;

  // control register fields
  localparam int CTRL_EN1 = 0;
  localparam int CTRL_EN2 = 1;
  localparam int CTRL_EN3 = 2;
  localparam int CTRL_ERREN = 3;
  localparam int CTRL_TWOWAY = 4;
  localparam int CTRL_DIRECT = 5;
  localparam int CTRL_SWSHUT = 6;
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

  // host interrupt enable fields
  localparam int HIRQ_IRQ1_C1 = 0;
  localparam int HIRQ_IRQ12_C1 = 1;
  localparam int HIRQ_C2_LO = 2;
  localparam int HIRQ_C3_LO = 7;
  localparam int HIRQ_W = 12;
  localparam logic [HIRQ_W-1:0] HIRQ_RST = 12'h000;

  // status register fields
  localparam int STAT_QUIET = 0;
  localparam int STAT_CKRQ = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_HRST = 3;
  localparam int STAT_SHUT = 4;
  localparam int STAT_ABORT = 5;
  localparam int STAT_IRQ_LO = 6;

  // frame layout
  localparam logic [4:0] FRAME_SMI = 5'h03;
  localparam logic [4:0] FRAME_IRQ1 = 5'h02;
  localparam logic [4:0] FRAME_IRQ6 = 5'h07;
  localparam logic [4:0] FRAME_IRQ9 = 5'h0a;
  localparam logic [4:0] FRAME_IRQ12 = 5'h0d;
  localparam logic [4:0] FRAME_LAST = 5'h11;
  localparam logic [1:0] PH_SAMPLE = 2'h0;
  localparam logic [1:0] PH_RECOVER = 2'h1;
  localparam logic [1:0] PH_TURN = 2'h2;
  localparam logic [2:0] STOP_QUIET_LOW = 3'h2;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_START = 2'b01,
    SQ_FRAME = 2'b10,
    SQ_STOP = 2'b11
  } sirq_seq_t;

  // byte-lane merge of a write into a register image
  function automatic logic [31:0] sirq_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

//--- design/sirq_sync.sv
// two-flop synchroniser for pins from outside the clk_in domain
// assumes inputs are levels; the first stage feeds only the second

module sirq_sync
  import sirq_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // system
  input wire logic clk_in,
  input wire logic rst_in,
  // levels
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule // sirq_sync

//--- design/sirq_local_irq.sv
// combines receive-complete, mode events and error flags into local irqs
// assumes level inputs from the lpc datapath on clk_in

module sirq_local_irq
  import sirq_pkg::*;
(
  // system
  input wire logic clk_in,
  input wire logic rst_in,
  // enables
  input wire logic [2:0] rx_en_in,
  input wire logic error_irq_en_in,
  input wire logic twoway_reg_enable_in,
  // sources
  input wire logic [2:0] rxreg_full_in,
  input wire logic twoway_last_full_in,
  input wire logic [4:0] hs_evt_in,
  input wire logic [11:0] blk_evt_in,
  input wire logic [2:0] err_flags_in,
  // irqs
  output logic [3:0] irq_out
);

  logic [3:0] irq_d;
  logic [3:0] irq_q;

  always_comb
  begin
    irq_d[0] = rx_en_in[0] & rxreg_full_in[0];
    irq_d[1] = rx_en_in[1] & rxreg_full_in[1];
    irq_d[2] = (rx_en_in[2] & rxreg_full_in[2])
             | (rx_en_in[2] & twoway_reg_enable_in & twoway_last_full_in)
             | (|hs_evt_in) | (|blk_evt_in);
    irq_d[3] = error_irq_en_in & (|err_flags_in);
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      irq_q <= 4'h0;
    end
    else
    begin
      irq_q <= irq_d;
    end
  end

  assign irq_out = irq_q;

endmodule // sirq_local_irq

//--- dv/sirq_props.sv
// checker for the serialized interrupt slave, top ports only
// assumes lclk states of 12 to 13 clk_in cycles
module sirq_props (
  // system
  input wire logic clk_in,
  input wire logic rst_in,
  // bus and pins
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic lreset_n_in,
  input wire logic lpcpd_n_in,
  input wire logic serirq_out,
  input wire logic serirq_oe_out,
  input wire logic clkrun_out,
  input wire logic clkrun_oe_out,
  // irq sources and irqs
  input wire logic [2:0] input_data_reg_full_in,
  input wire logic twoway_reg_last_full_in,
  input wire logic [4:0] hs_evt_in,
  input wire logic [11:0] blk_evt_in,
  input wire logic rx_done_irq_ch1_out,
  input wire logic rx_done_irq_ch2_out,
  input wire logic rx_done_irq_ch3_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // run lengths; repetition cannot reach a whole state
  logic [5:0] low_q, low_d, drv_q, drv_d, ck_q, ck_d;
  always_comb
  begin
    low_d = (serirq_oe_out && !serirq_out) ? low_q + 6'h01 : 6'h00;
    drv_d = serirq_oe_out ? drv_q + 6'h01 : 6'h00;
    ck_d = clkrun_oe_out ? ck_q + 6'h01 : 6'h00;
  end
  always_ff @(posedge clk_in)
  begin
    low_q <= rst_in ? 6'h00 : low_d;
    drv_q <= rst_in ? 6'h00 : drv_d;
    ck_q <= rst_in ? 6'h00 : ck_d;
  end
  a_wait_one_cycle: assert property ($rose(avs_read_in || avs_write_in) |->
    avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("bad waitrequest");
  a_irq1_cause: assert property (
    $rose(rx_done_irq_ch1_out) |-> $past(input_data_reg_full_in[0])) else $error("irq1");
  a_irq2_cause: assert property (
    $rose(rx_done_irq_ch2_out) |-> $past(input_data_reg_full_in[1])) else $error("irq2");
  a_irq3_cause: assert property ($rose(rx_done_irq_ch3_out) |->
    $past(input_data_reg_full_in[2] || twoway_reg_last_full_in || (|hs_evt_in) || (|blk_evt_in)))
    else $error("irq3");
  a_shutdown_float: assert property (!lpcpd_n_in [*4] |->
    !serirq_oe_out && !clkrun_oe_out) else $error("driven in shutdown");
  a_lreset_float: assert property (!lreset_n_in [*4] |->
    !serirq_oe_out && !clkrun_oe_out) else $error("driven in lpc reset");
  a_drive_starts_low: assert property (
    $rose(serirq_oe_out) |-> !serirq_out) else $error("drive not low first");
  a_low_one_state: assert property (low_q <= 6'h0e) else $error("low too long");
  a_low_full_state: assert property ($fell(serirq_oe_out && !serirq_out) &&
    lpcpd_n_in && lreset_n_in |-> low_q >= 6'h0b) else $error("low too short");
  a_drive_two_states: assert property (drv_q <= 6'h1c) else $error("held too long");
  a_clkrun_pull_low: assert property (
    clkrun_oe_out |-> !clkrun_out) else $error("clkrun not low");
  a_clkrun_pulse_len: assert property ($fell(clkrun_oe_out) && lpcpd_n_in &&
    lreset_n_in |-> ck_q == 6'h19) else $error("clkrun pulse length");
  c_clkrun: cover property ($rose(clkrun_oe_out));
  c_drive: cover property ($rose(serirq_oe_out));
  c_irq3: cover property ($rose(rx_done_irq_ch3_out));
endmodule // sirq_props

bind sirq_top sirq_props chk_u (.clk_in(clk_in), .rst_in(rst_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out), .lreset_n_in(lreset_n_in),
  .lpcpd_n_in(lpcpd_n_in), .serirq_out(serirq_out), .serirq_oe_out(serirq_oe_out),
  .clkrun_out(clkrun_out), .clkrun_oe_out(clkrun_oe_out),
  .input_data_reg_full_in(input_data_reg_full_in),
  .twoway_reg_last_full_in(twoway_reg_last_full_in), .hs_evt_in(hs_evt_in),
  .blk_evt_in(blk_evt_in), .rx_done_irq_ch1_out(rx_done_irq_ch1_out),
  .rx_done_irq_ch2_out(rx_done_irq_ch2_out), .rx_done_irq_ch3_out(rx_done_irq_ch3_out));

//--- dv/sirq_host.sv
// host side of the serial interrupt line: lclk, start and stop frames
// assumes open-drain serirq and clkrun with pull-ups
module sirq_host (
  // device pins
  input wire logic sirq_oe_in,
  input wire logic sirq_val_in,
  input wire logic clkrun_oe_in,
  // resolved lines
  output logic lclk_out,
  output logic serirq_out,
  output logic clkrun_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic run = 1'b1;
  logic host_low = 1'b0;
  logic busy = 1'b0;
  logic [17:1] seen = '0;
  // pull-ups: a released line reads high
  assign serirq_out = !(host_low || (sirq_oe_in && !sirq_val_in));
  assign clkrun_out = !clkrun_oe_in;
  initial lclk_out = 1'b0;
  always
  begin
    #62.5;
    if (run) lclk_out = ~lclk_out;
  end
  always @(negedge clkrun_out) run = 1'b1;
  task automatic halt();
    @(negedge lclk_out);
    run = 1'b0;
  endtask
  task automatic states(input int n, input logic low);
    repeat (n) @(posedge lclk_out) host_low = low;
  endtask
  task automatic cycle(input logic slave_start, input int stop_low);
    int n;
    busy = 1'b1;
    seen = '0;
    if (slave_start)
    begin
      for (n = 0; n < 64 && serirq_out !== 1'b0; n++) @(negedge lclk_out);
      // three host states after the device state
      states(3, 1'b1);
    end
    else
      states(4, 1'b1);
    // recover and turnaround left to the pull-up
    states(2, 1'b0);
    // sample state 0 of each frame
    for (n = 1; n <= 17; n++)
    begin
      @(posedge lclk_out);
      @(negedge lclk_out);
      seen[n] = !serirq_out;
      repeat (2) @(posedge lclk_out);
    end
    // stop frame picks the next mode
    states(1, 1'b0);
    states(stop_low, 1'b1);
    states(3, 1'b0);
    busy = 1'b0;
  endtask
endmodule // sirq_host

//--- dv/tb_top.sv
// self-checking bench for the serialized interrupt slave
// assumes the host model resolves the open-drain lines
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  int bad_count = 0;
  int cmp_count = 0;
  int i;
  int fr[12] = '{2, 13, 3, 7, 10, 11, 12, 3, 7, 10, 11, 12};
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata, rdo;
  logic lres_n = 1'b1;
  logic pd_n = 1'b1;
  logic twl = 1'b0;
  logic abort_p = 1'b0;
  logic [2:0] host_rd = 3'h0;
  logic [2:0] full = 3'h0;
  logic [4:0] hs = 5'h0;
  logic [11:0] blk = 12'h0;
  logic ck_seen = 1'b0;
  logic self_seen = 1'b0;
  logic wreq, s_out, s_oe, c_out, c_oe, irq1, irq2, irq3, eirq, lclk, s_line, c_line;
  sirq_top dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdo), .avs_waitrequest_out(wreq), .lclk_in(lclk),
    .lreset_n_in(lres_n), .lpcpd_n_in(pd_n), .serirq_in(s_line), .serirq_out(s_out),
    .serirq_oe_out(s_oe), .clkrun_in(c_line), .clkrun_out(c_out), .clkrun_oe_out(c_oe),
    .output_data_reg_read_in(host_rd), .input_data_reg_full_in(full),
    .twoway_reg_last_full_in(twl), .hs_evt_in(hs), .blk_evt_in(blk),
    .cycle_abort_evt_in(abort_p), .rx_done_irq_ch1_out(irq1), .rx_done_irq_ch2_out(irq2),
    .rx_done_irq_ch3_out(irq3), .error_irq_out(eirq));
  sirq_host host_u (
    .sirq_oe_in(s_oe), .sirq_val_in(s_out), .clkrun_oe_in(c_oe),
    .lclk_out(lclk), .serirq_out(s_line), .clkrun_out(c_line));
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    if (c_oe === 1'b1) ck_seen <= 1'b1;
    if (s_oe === 1'b1 && !host_u.busy) self_seen <= 1'b1;
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one avalon access; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (wreq !== 1'b0 && n < 20);
    rdata = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0)
    begin
      bad_count++;
      end_of_test();
    end
  endtask
  initial
  begin
    #800us;
    bad_count++;
    end_of_test();
  end
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      bus(1'b0, 4'(i * 4), 32'h0);
      `CHK(rdata, 32'h0)
    end
    bus(1'b1, 4'h0, 32'h1f);
    for (i = 0; i < 21; i++)
    begin
      @(posedge clk_in);
      {blk, hs, twl, full} <= 21'h1 << i;
      repeat (3) @(posedge clk_in);
      `CHK({irq3, irq2, irq1}, (i < 2) ? 3'(1 << i) : 3'h4)
    end
    bus(1'b1, 4'h0, 32'h0f);
    @(posedge clk_in);
    {blk, hs, twl, full} <= 21'h8;
    abort_p <= 1'b1;
    @(posedge clk_in);
    abort_p <= 1'b0;
    twl <= 1'b0;
    repeat (3) @(posedge clk_in);
    `CHK({eirq, irq3}, 2'b10)
    bus(1'b1, 4'h8, 32'h20);
    repeat (3) @(posedge clk_in);
    `CHK(eirq, 1'b0)
    for (i = 0; i < 12; i++)
    begin
      bus(1'b1, 4'h4, 32'h1 << i);
      host_u.cycle(1'b0, 3);
      `CHK(host_u.seen, 17'h1 << (fr[i] - 1))
    end
    repeat (400) @(posedge clk_in);
    `CHK({ck_seen, self_seen}, 2'b00)
    bus(1'b1, 4'h4, 32'h0);
    host_u.cycle(1'b0, 2);
    bus(1'b0, 4'h8, 32'h0);
    `CHK(rdata[0], 1'b1)
    host_u.halt();
    bus(1'b1, 4'h4, 32'h2);
    host_u.cycle(1'b1, 3);
    `CHK(host_u.seen, 17'h1 << 12)
    `CHK(ck_seen, 1'b1)
    bus(1'b0, 4'h8, 32'h0);
    `CHK(rdata[0], 1'b0)
    for (i = 0; i < 2; i++)
    begin
      bus(1'b1, 4'h0, (i == 1) ? 32'h2f : 32'h0f);
      bus(1'b1, 4'h4, 32'h85);
      @(posedge clk_in);
      host_rd <= 3'h7;
      @(posedge clk_in);
      host_rd <= 3'h0;
      bus(1'b0, 4'h4, 32'h0);
      `CHK(rdata, (i == 1) ? 32'h84 : 32'h0)
    end
    @(posedge clk_in);
    pd_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    `CHK({s_oe, c_oe, eirq}, 3'b001)
    pd_n <= 1'b1;
    lres_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    bus(1'b0, 4'h4, 32'h0);
    `CHK(rdata, 32'h0)
    bus(1'b0, 4'h8, 32'h0);
    `CHK(rdata[4:3], 2'b01)
    lres_n <= 1'b1;
    end_of_test();
  end
endmodule // tb_top
